/* common/timer_pkg.sv */
/*
  constants, mode codes and reset values for the three-mode timer block.
  assumes one clock domain and software control through plain ports.
*/
// What this block does
// - decode mode code into PWM, event, capture
// - PWM reload from A requests A interrupt
// - PWM reload from B requests B interrupt
// - the two interrupt enables act independently
// - event mode counts pin_a edges, chosen polarity
// - event underflow sets pend_a, enable gates it
// - event mode pin_b rising edge sets pend_b
// - event mode never drives pin_a
// - capture mode counter runs every cycle
// - capture copies counter on selected pin edge
// - trigger polarity per pin pair: a/b rise/rise, rise/fall or fall/fall
// - capture triggers set pend_a and pend_b
// - capture underflow sets run flag, A interrupt
// - run flag starts/stops PWM and event counting
// - first reload from A, then alternate from B
// - PWM counts each cycle, toggles pin_a optionally
// - PWM underflows set pend_a, pend_b alternately
package timer_pkg;
  localparam int COUNT_WIDTH = 16;
  localparam int MODE_WIDTH = 3;
  localparam logic [MODE_WIDTH-1:0] MODE_PWM_TOGGLE = 3'h5;
  localparam logic [MODE_WIDTH-1:0] MODE_PWM_PLAIN = 3'h4;
  localparam logic [MODE_WIDTH-1:0] MODE_EVENT_RISE = 3'h0;
  localparam logic [MODE_WIDTH-1:0] MODE_EVENT_FALL = 3'h1;
  localparam logic [MODE_WIDTH-1:0] MODE_CAP_RISE_RISE = 3'h2;
  localparam logic [MODE_WIDTH-1:0] MODE_CAP_RISE_FALL = 3'h6;
  localparam logic [MODE_WIDTH-1:0] MODE_CAP_FALL_FALL = 3'h3;
  localparam logic [MODE_WIDTH-1:0] MODE_CAP_FALL_FALL_ALT = 3'h7;
  localparam int SYNC_STAGES = 3;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam logic RESET_FLAG = 1'b0;
  localparam logic RESET_PIN_LEVEL = 1'b0;
  typedef logic [MODE_WIDTH-1:0] mode_t;
  typedef enum logic [1:0] {
    kind_pwm,
    kind_event,
    kind_capture
  } mode_kind_e;
endpackage

/* common/pin_edge_if.sv */
/*
  carrier for the filtered level and edge pulses of one timer pin.
  assumes the edge detector and its user share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface pin_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport source (output level, rise, fall);
  modport sink (input level, rise, fall);
endinterface
`default_nettype wire

/* rtl/pin_edge_detect.sv */
/*
  three-stage synchroniser and edge detector for one timer pin.
  assumes the pin is asynchronous to clock; reset synchronous, active high.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  pin_edge_if.source edges
);
  import timer_pkg::*;

  logic [SYNC_STAGES-1:0] sync;
  logic level;

  // shift chain; stage 0 feeds only stage 1
  always_ff @(posedge clock) begin
    if (reset) begin
      sync <= {SYNC_STAGES{RESET_PIN_LEVEL}};
    end else begin
      sync <= {sync[SYNC_STAGES-2:0], pin};
    end
  end

  // accept a change once stages one and two agree
  always_ff @(posedge clock) begin
    if (reset) begin
      level <= RESET_PIN_LEVEL;
    end else if (sync[1] == sync[2]) begin
      level <= sync[2];
    end
  end

  assign edges.level = level;
  assign edges.rise = (sync[1] == sync[2]) && sync[2] && !level;
  assign edges.fall = (sync[1] == sync[2]) && !sync[2] && level;
endmodule
`default_nettype wire

/* rtl/triple_mode_timer_block.sv */
/*
  16-bit timer block: PWM, external event counter and dual input capture.
  assumes software drives the control ports synchronously to clock;
  pin_a and pin_b come from outside and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module triple_mode_timer_block #(
  parameter int WIDTH = timer_pkg::COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire timer_pkg::mode_t mode_select,
  input wire logic irq_en_a,
  input wire logic irq_en_b,
  input wire logic write_run_flag,
  input wire logic run_flag_wdata,
  input wire logic clear_pend_a,
  input wire logic clear_pend_b,
  input wire logic write_counter,
  input wire logic write_reload_a,
  input wire logic write_reload_b,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  input wire logic pin_b_in,
  output logic [WIDTH-1:0] counter16,
  output logic [WIDTH-1:0] reload_capture_a,
  output logic [WIDTH-1:0] reload_capture_b,
  output logic run_or_underflow_flag,
  output logic pend_a,
  output logic pend_b,
  output logic irq
);
  import timer_pkg::*;

  if (WIDTH < 2 || WIDTH > 32) begin : width_check
    $error("WIDTH must lie between 2 and 32");
  end

  pin_edge_if edge_a ();
  pin_edge_if edge_b ();

  pin_edge_detect sync_a (
    .clock(clock),
    .reset(reset),
    .pin(pin_a_in),
    .edges(edge_a.source)
  );

  pin_edge_detect sync_b (
    .clock(clock),
    .reset(reset),
    .pin(pin_b_in),
    .edges(edge_b.source)
  );

  mode_kind_e kind;
  logic trig_a_falling;
  logic trig_b_falling;
  logic toggle_enable;

  // mode decode
  always_comb begin
    kind = kind_capture;
    trig_a_falling = 1'b0;
    trig_b_falling = 1'b0;
    toggle_enable = 1'b0;
    unique case (mode_select)
      MODE_PWM_TOGGLE: begin
        kind = kind_pwm;
        toggle_enable = 1'b1;
      end
      MODE_PWM_PLAIN: begin
        kind = kind_pwm;
      end
      MODE_EVENT_RISE: begin
        kind = kind_event;
      end
      MODE_EVENT_FALL: begin
        kind = kind_event;
        trig_a_falling = 1'b1;
      end
      MODE_CAP_RISE_RISE: begin
        kind = kind_capture;
      end
      MODE_CAP_RISE_FALL: begin
        kind = kind_capture;
        trig_b_falling = 1'b1;
      end
      MODE_CAP_FALL_FALL, MODE_CAP_FALL_FALL_ALT: begin
        kind = kind_capture;
        trig_a_falling = 1'b1;
        trig_b_falling = 1'b1;
      end
    endcase
  end

  logic trig_a;
  logic trig_b;
  logic tick;
  logic underflow;
  logic reload_from_b;
  logic pwm_reload_a;
  logic pwm_reload_b;

  assign trig_a = trig_a_falling ? edge_a.fall : edge_a.rise;
  assign trig_b = trig_b_falling ? edge_b.fall : edge_b.rise;

  // count enable per mode
  always_comb begin
    tick = 1'b0;
    unique case (kind)
      kind_pwm: tick = run_or_underflow_flag;
      kind_event: tick = run_or_underflow_flag && trig_a;
      kind_capture: tick = 1'b1;
    endcase
  end

  assign underflow = tick && !write_counter && (counter16 == '0);
  assign pwm_reload_a = underflow && (kind == kind_pwm) && !reload_from_b;
  assign pwm_reload_b = underflow && (kind == kind_pwm) && reload_from_b;

  // down counter with reload
  always_ff @(posedge clock) begin
    if (reset) begin
      counter16 <= '0;
    end else if (write_counter) begin
      counter16 <= write_data;
    end else if (pwm_reload_a) begin
      counter16 <= reload_capture_a;
    end else if (pwm_reload_b) begin
      counter16 <= reload_capture_b;
    end else if (underflow && kind == kind_event) begin
      counter16 <= reload_capture_a;
    end else if (tick) begin
      counter16 <= counter16 - 1'b1;
    end
  end

  // alternation: first underflow uses A, then B, A, ...
  always_ff @(posedge clock) begin
    if (reset) begin
      reload_from_b <= 1'b0;
    end else if (kind != kind_pwm) begin
      reload_from_b <= 1'b0;
    end else if (underflow) begin
      reload_from_b <= !reload_from_b;
    end
  end

  // register A: reload value or capture of pin_a
  always_ff @(posedge clock) begin
    if (reset) begin
      reload_capture_a <= '0;
    end else if (kind == kind_capture && trig_a) begin
      reload_capture_a <= counter16;
    end else if (write_reload_a) begin
      reload_capture_a <= write_data;
    end
  end

  // register B: reload value or capture of pin_b
  always_ff @(posedge clock) begin
    if (reset) begin
      reload_capture_b <= '0;
    end else if (kind == kind_capture && trig_b) begin
      reload_capture_b <= counter16;
    end else if (write_reload_b) begin
      reload_capture_b <= write_data;
    end
  end

  logic set_a;
  logic set_b;
  logic set_run;

  // pending sources per mode
  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    set_run = 1'b0;
    unique case (kind)
      kind_pwm: begin
        set_a = pwm_reload_a;
        set_b = pwm_reload_b;
      end
      kind_event: begin
        set_a = underflow;
        set_b = edge_b.rise;
      end
      kind_capture: begin
        set_a = trig_a;
        set_b = trig_b;
        set_run = underflow;
      end
    endcase
  end

  // sticky pending flags, set beats clear
  always_ff @(posedge clock) begin
    if (reset) begin
      pend_a <= RESET_FLAG;
    end else if (set_a) begin
      pend_a <= 1'b1;
    end else if (clear_pend_a) begin
      pend_a <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pend_b <= RESET_FLAG;
    end else if (set_b) begin
      pend_b <= 1'b1;
    end else if (clear_pend_b) begin
      pend_b <= 1'b0;
    end
  end

  // run control, or underflow pending in capture mode
  always_ff @(posedge clock) begin
    if (reset) begin
      run_or_underflow_flag <= RESET_FLAG;
    end else if (set_run) begin
      run_or_underflow_flag <= 1'b1;
    end else if (write_run_flag) begin
      run_or_underflow_flag <= run_flag_wdata;
    end
  end

  // pwm output pin
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_a_out <= RESET_PIN_LEVEL;
    end else if (toggle_enable && underflow) begin
      pin_a_out <= !pin_a_out;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_a_oe <= 1'b0;
    end else begin
      pin_a_oe <= (kind == kind_pwm);
    end
  end

  // interrupt request; software sorts A causes in capture mode
  assign irq = (pend_a && irq_en_a) || (pend_b && irq_en_b)
    || (kind == kind_capture && run_or_underflow_flag && irq_en_a);
endmodule
`default_nettype wire

/* tb/timer_assertions.sv */
/* port checker for the three-mode timer block.
   assumes one clock, bound into triple_mode_timer_block. */
`timescale 1ns/1ns
`default_nettype none
module timer_assertions #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire timer_pkg::mode_t mode_select,
  input wire logic irq_en_a,
  input wire logic irq_en_b,
  input wire logic write_counter,
  input wire logic clear_pend_a,
  input wire logic [WIDTH-1:0] counter16,
  input wire logic [WIDTH-1:0] reload_capture_a,
  input wire logic [WIDTH-1:0] reload_capture_b,
  input wire logic run_or_underflow_flag,
  input wire logic pend_a,
  input wire logic pend_b,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic irq
);
  import timer_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire pwm = mode_select[2:1] == 2'h2;
  wire cap = mode_select[1];
  logic alt;
  // expected reload side: A first, then alternating
  always_ff @(posedge clock) begin
    if (reset || !pwm) begin
      alt <= 1'b0;
    end else if (run_or_underflow_flag && !write_counter && counter16 == '0) begin
      alt <= !alt;
    end
  end
  sequence s_run_pwm;
    pwm && run_or_underflow_flag && !write_counter;
  endsequence
  sequence s_uflow;
    s_run_pwm ##0 counter16 == '0;
  endsequence
  a_irq_or_sources: assert property (
    irq == (pend_a && irq_en_a || pend_b && irq_en_b || cap && run_or_underflow_flag && irq_en_a))
    else $error("irq not the enabled pending sources");
  a_pwm_counts_down: assert property (
    s_run_pwm ##0 counter16 != '0 |=> counter16 == $past(counter16) - 1'b1)
    else $error("pwm counter did not step");
  a_pwm_reload_flag: assert property (
    s_uflow ##0 !alt |=> pend_a && counter16 == $past(reload_capture_a))
    else $error("pwm reload from a wrong");
  a_pwm_reload_b: assert property (
    s_uflow ##0 alt |=> pend_b && counter16 == $past(reload_capture_b))
    else $error("pwm reload from b wrong");
  a_pwm_pin_toggle: assert property (
    s_uflow ##0 mode_select[0] |=> pin_a_out != $past(pin_a_out))
    else $error("pin did not toggle");
  a_stop_holds: assert property (
    !cap && !run_or_underflow_flag && !write_counter |=> $stable(counter16))
    else $error("stopped counter moved");
  a_event_no_drive: assert property (
    mode_select[2:1] == 2'h0 |=> !pin_a_oe)
    else $error("pin driven in event mode");
  a_capture_runs: assert property (
    cap && !write_counter |=> counter16 == $past(counter16) - 1'b1)
    else $error("capture counter did not run");
  a_capture_uflow: assert property (
    cap && counter16 == '0 && !write_counter |=> run_or_underflow_flag)
    else $error("capture underflow not flagged");
  a_pend_sticky: assert property (
    pend_a && !clear_pend_a |=> pend_a)
    else $error("pend_a dropped by itself");
endmodule
bind triple_mode_timer_block timer_assertions #(.WIDTH(WIDTH)) u_timer_assertions (
  .clock(clock),
  .reset(reset),
  .mode_select(mode_select),
  .irq_en_a(irq_en_a),
  .irq_en_b(irq_en_b),
  .write_counter(write_counter),
  .clear_pend_a(clear_pend_a),
  .counter16(counter16),
  .reload_capture_a(reload_capture_a),
  .reload_capture_b(reload_capture_b),
  .run_or_underflow_flag(run_or_underflow_flag),
  .pend_a(pend_a),
  .pend_b(pend_b),
  .pin_a_out(pin_a_out),
  .pin_a_oe(pin_a_oe),
  .irq(irq)
);
`default_nettype wire

/* tb/pin_source_model.sv */
/* pulse sources and load at the timer pins.
   assumes levels are held long enough by the caller. */
`timescale 1ns/1ns
`default_nettype none
module pin_source_model (
  input wire logic clock,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  output logic pin_a_in,
  output logic pin_b_in
);
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  // the load sees the driven level while the block drives
  assign pin_a_in = pin_a_oe ? pin_a_out : lvl_a;
  assign pin_b_in = lvl_b;
  task set_pin(input logic b, input logic v);
    @(posedge clock);
    if (b) lvl_b <= v;
    else lvl_a <= v;
  endtask
endmodule
`default_nettype wire

/* tb/tb_triple_mode_timer_block.sv */
/* self-checking bench for the three-mode timer block.
   assumes the pin model and checker files are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_triple_mode_timer_block;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  mode_t mode_select = MODE_EVENT_RISE;
  logic irq_en_a = 1'b0;
  logic irq_en_b = 1'b0;
  logic [5:0] stb = '0;
  logic run_flag_wdata = 1'b0;
  logic [15:0] write_data = '0;
  logic pin_a_in, pin_a_out, pin_a_oe, pin_b_in, run_or_underflow_flag, pend_a, pend_b, irq;
  logic [15:0] counter16, reload_capture_a, reload_capture_b;
  int n_errors = 0;
  int checked = 0;
  always #50 clock = ~clock;
  triple_mode_timer_block u_triple_mode_timer_block (.clock, .reset, .mode_select,
    .irq_en_a, .irq_en_b, .write_run_flag(stb[2]), .run_flag_wdata, .clear_pend_a(stb[3]),
    .clear_pend_b(stb[4]), .write_counter(stb[0]), .write_reload_a(stb[1]),
    .write_reload_b(stb[5]), .write_data, .pin_a_in, .pin_a_out, .pin_a_oe, .pin_b_in,
    .counter16, .reload_capture_a, .reload_capture_b, .run_or_underflow_flag, .pend_a,
    .pend_b, .irq);
  pin_source_model u_pin_source_model (.clock, .pin_a_out, .pin_a_oe, .pin_a_in, .pin_b_in);
  // k: 0 counter, 1 reload a, 2 run flag, 3 clear a, 4 clear b, 5 reload b
  task wr(input int k, input logic [15:0] d);
    @(posedge clock);
    stb <= 6'h01 << k;
    write_data <= d;
    run_flag_wdata <= d[0];
    @(posedge clock);
    stb <= '0;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task idle;
    repeat (6) @(posedge clock);
    @(negedge clock);
  endtask
  task wait_flag(input int w);
    for (int i = 0; i < 60; i++) begin
      @(negedge clock);
      if (w == 0 && pend_a === 1'b1 || w == 1 && pend_b === 1'b1) break;
      if (w == 2 && run_or_underflow_flag === 1'b1) break;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk({run_or_underflow_flag, pend_a, pend_b, irq, pin_a_oe}, 16'h0000);
    wr(1, 16'h0003);
    wr(5, 16'h0002);
    wr(0, 16'h0001);
    mode_select <= MODE_PWM_TOGGLE;
    irq_en_a <= 1'b1;
    wr(2, 16'h0001);
    wait_flag(0);
    chk(counter16, 16'h0003);
    chk(pend_b, 1'b0);
    chk(irq, 1'b1);
    chk(pin_a_oe, 1'b1);
    chk(pin_a_out, 1'b1);
    wait_flag(1);
    chk(counter16, 16'h0002);
    chk(pin_a_out, 1'b0);
    wr(2, 16'h0000);
    wr(3, 16'h0000);
    @(negedge clock);
    chk(irq, 1'b0);
    chk(counter16, 16'h0000);
    @(posedge clock);
    irq_en_b <= 1'b1;
    @(negedge clock);
    chk(irq, 1'b1);
    $display("pwm test done");
    @(posedge clock);
    irq_en_a <= 1'b0;
    mode_select <= MODE_EVENT_RISE;
    wr(4, 16'h0000);
    wr(1, 16'h0005);
    wr(0, 16'h0001);
    wr(2, 16'h0001);
    u_pin_source_model.set_pin(1'b0, 1'b1);
    idle;
    chk(counter16, 16'h0000);
    u_pin_source_model.set_pin(1'b0, 1'b0);
    idle;
    chk(counter16, 16'h0000);
    u_pin_source_model.set_pin(1'b0, 1'b1);
    idle;
    chk(counter16, 16'h0005);
    chk({pend_a, irq, pin_a_oe}, 3'h4);
    u_pin_source_model.set_pin(1'b1, 1'b1);
    idle;
    chk({pend_b, irq}, 2'h3);
    @(posedge clock);
    mode_select <= MODE_EVENT_FALL;
    u_pin_source_model.set_pin(1'b0, 1'b0);
    idle;
    chk(counter16, 16'h0004);
    $display("event test done");
    wr(0, 16'h0100);
    mode_select <= MODE_CAP_RISE_RISE;
    wr(2, 16'h0000);
    wr(3, 16'h0000);
    wr(4, 16'h0000);
    u_pin_source_model.set_pin(1'b0, 1'b1);
    wait_flag(0);
    chk(reload_capture_a, counter16 + 16'h0001);
    chk(pend_b, 1'b0);
    @(posedge clock);
    mode_select <= MODE_CAP_RISE_FALL;
    u_pin_source_model.set_pin(1'b1, 1'b0);
    wait_flag(1);
    chk(reload_capture_b, counter16 + 16'h0001);
    @(posedge clock);
    mode_select <= MODE_CAP_FALL_FALL;
    wr(3, 16'h0000);
    u_pin_source_model.set_pin(1'b0, 1'b0);
    wait_flag(0);
    chk(reload_capture_a, counter16 + 16'h0001);
    @(posedge clock);
    mode_select <= MODE_CAP_FALL_FALL_ALT;
    wr(3, 16'h0000);
    u_pin_source_model.set_pin(1'b0, 1'b1);
    idle;
    chk(pend_a, 1'b0);
    u_pin_source_model.set_pin(1'b0, 1'b0);
    wait_flag(0);
    chk(pend_a, 1'b1);
    @(posedge clock);
    irq_en_a <= 1'b1;
    irq_en_b <= 1'b0;
    wr(3, 16'h0000);
    wr(0, 16'h0003);
    wait_flag(2);
    chk({run_or_underflow_flag, pend_a, irq}, 3'h5);
    $display("capture test done");
    @(posedge clock);
    mode_select <= MODE_PWM_PLAIN;
    wr(2, 16'h0000);
    wr(3, 16'h0000);
    wr(1, 16'h0002);
    wr(0, 16'h0001);
    wr(2, 16'h0001);
    wait_flag(0);
    chk(counter16, 16'h0002);
    chk(pin_a_out, 1'b0);
    $display("pwm plain test done");
    print_verdict;
  end
endmodule
`default_nettype wire
